// [core/fcrb_config_regs.sv]
`timescale 1ns/1ps
module fcrb_config_regs (
   // clock and resets
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic hard_rst_i,
   // host port, same clock domain
   input wire logic cfg_mode_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic port_sel_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // drive signals from the disk core
   input wire logic [3:0] core_sel_i,
   input wire logic [3:0] core_motor_i,
   input wire logic den_rate_i,
   input wire logic den1_rate_i,
   // pins out
   output logic [3:0] drive_sel_o,
   output logic [3:0] motor_sel_o,
   output logic density_o,
   output logic second_density_output_o,
   output logic second_density_oe_o,
   // configuration to the disk core
   output logic enhanced_mode_o,
   output logic [1:0] interface_mode_o,
   output logic four_drive_decoder_select_o,
   output logic dma_burst_select_o,
   output logic [7:0] drive_type_o
);
   typedef struct packed {
      logic [7:0] index;
      logic access_lock;
      logic [7:0] mode;
      logic [7:0] ext;
      logic [7:0] dtype;
      logic [7:0] rdata;
      logic rvalid;
      logic [3:0] sel;
      logic [3:0] motor;
      logic den;
      logic den1;
      logic den1_oe;
   } fcrb_state_t;

   fcrb_state_t st, next_st;
   logic [1:0] raw_rate;
   logic [1:0] sync_rate;
   logic [3:0] map_sel;
   logic [3:0] map_motor;
   logic map_den;
   logic hard_rst_s;
   logic idx_wr;
   logic idx_rd;
   logic data_wr;
   logic data_rd;
   logic wr_lock;
   logic wr_mode;
   logic wr_ext;
   logic wr_dtype;
   logic [7:0] reg_view;

   // rate inputs come from the data separator domain
   assign raw_rate = {den1_rate_i, den_rate_i};

   fcrb_pin_sync #(.W(2)) u_rate_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(raw_rate),
      .q_o(sync_rate)
   );

   // the hard reset pin is not tied to clk_i
   fcrb_pin_sync #(.W(1)) u_hard_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(hard_rst_i),
      .q_o(hard_rst_s)
   );

   fcrb_drive_map u_map (
      .swap_i(st.ext[fcrb_pkg::EXT_SWAP_BIT]),
      .den_force_i(st.ext[fcrb_pkg::EXT_DEN_LO +: 2]),
      .den_rate_i(sync_rate[0]),
      .sel_i(core_sel_i),
      .motor_i(core_motor_i),
      .sel_o(map_sel),
      .motor_o(map_motor),
      .den_o(map_den)
   );

   // one compare for every write index decode, the read mux uses a case
   function automatic logic idx_hit(input logic [7:0] idx,
                                    input logic [7:0] target);
      idx_hit = (idx == target);
   endfunction

   function automatic logic [7:0] lock_view(input logic lk);
      lock_view = 8'h00;
      lock_view[fcrb_pkg::LOCK_ONE_BIT] = 1'b1;
      lock_view[fcrb_pkg::LOCK_BIT] = lk;
   endfunction

   // mode and ext are masked on the way in and out, so their reserved bits never read one
   function automatic logic [7:0] keep_bits(input logic [7:0] v,
                                            input logic [7:0] mask);
      keep_bits = v & mask;
   endfunction

   // power-up defaults of every field in one place
   function automatic fcrb_state_t power_up_state();
      fcrb_state_t s;
      s.index = 8'h00;
      s.access_lock = fcrb_pkg::RST_LOCK[fcrb_pkg::LOCK_BIT];
      s.mode = fcrb_pkg::RST_MODE;
      s.ext = fcrb_pkg::RST_EXT;
      s.dtype = fcrb_pkg::RST_DTYPE;
      s.rdata = 8'h00;
      s.rvalid = 1'b0;
      s.sel = 4'h0;
      s.motor = 4'h0;
      s.den = 1'b0;
      s.den1 = 1'b0;
      // pin starts released, matching the tri-state default of bit 4
      s.den1_oe = 1'b0;
      power_up_state = s;
   endfunction

   // index port stays usable while the lock is shut
   assign idx_wr = cfg_mode_i & wr_i & ~port_sel_i;
   assign idx_rd = cfg_mode_i & rd_i & ~port_sel_i;
   // data port only works in config mode with the lock open
   assign data_wr = cfg_mode_i & wr_i & port_sel_i & st.access_lock;
   assign data_rd = cfg_mode_i & rd_i & port_sel_i & st.access_lock;

   // 02, 04 and other indices take no writes
   assign wr_lock = data_wr & idx_hit(st.index, fcrb_pkg::IDX_LOCK);
   assign wr_mode = data_wr & idx_hit(st.index, fcrb_pkg::IDX_MODE);
   assign wr_ext = data_wr & idx_hit(st.index, fcrb_pkg::IDX_EXT);
   assign wr_dtype = data_wr & idx_hit(st.index, fcrb_pkg::IDX_DTYPE);

   always_comb begin
      reg_view = 8'h00;
      case (st.index)
         fcrb_pkg::IDX_LOCK: begin
            reg_view = lock_view(st.access_lock);
         end
         fcrb_pkg::IDX_RSV2: begin
            reg_view = fcrb_pkg::RST_RSV2;
         end
         fcrb_pkg::IDX_MODE: begin
            reg_view = keep_bits(st.mode, fcrb_pkg::MODE_WMASK);
         end
         fcrb_pkg::IDX_RSV4: begin
            reg_view = fcrb_pkg::RST_RSV4;
         end
         fcrb_pkg::IDX_EXT: begin
            reg_view = keep_bits(st.ext, fcrb_pkg::EXT_WMASK);
         end
         fcrb_pkg::IDX_DTYPE: begin
            reg_view = st.dtype;
         end
         default: begin
            reg_view = 8'h00;
         end
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      next_st.rdata = 8'h00;
      if (idx_wr) begin
         next_st.index = wdata_i;
      end
      // only a clear is honoured, setting needs a reset
      if (wr_lock && !wdata_i[fcrb_pkg::LOCK_BIT]) begin
         next_st.access_lock = 1'b0;
      end
      if (wr_mode) begin
         next_st.mode = keep_bits(wdata_i, fcrb_pkg::MODE_WMASK);
      end
      if (wr_ext) begin
         next_st.ext = keep_bits(wdata_i, fcrb_pkg::EXT_WMASK);
      end
      if (wr_dtype) begin
         next_st.dtype = wdata_i;
      end
      // every read in config mode is answered, a blocked one with zero
      if (cfg_mode_i && rd_i) begin
         next_st.rvalid = 1'b1;
      end
      if (idx_rd) begin
         next_st.rdata = st.index;
      end else if (data_rd) begin
         next_st.rdata = reg_view;
      end
      next_st.sel = map_sel;
      next_st.motor = map_motor;
      next_st.den = map_den;
      next_st.den1 = sync_rate[1];
      // a set bit 4 is the tri-state default, so the enable is inverted
      next_st.den1_oe = !st.mode[fcrb_pkg::MODE_DEN1_BIT];
      // hard reset reopens the lock without touching other settings
      if (hard_rst_s) begin
         next_st.access_lock = 1'b1;
      end
   end

   // rst_i is the power-up reset that loads every default
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= power_up_state();
      end else begin
         st <= next_st;
      end
   end

   // straight from state flops
   assign rdata_o = st.rdata;
   assign rvalid_o = st.rvalid;
   assign drive_sel_o = st.sel;
   assign motor_sel_o = st.motor;
   assign density_o = st.den;
   assign second_density_output_o = st.den1;
   assign second_density_oe_o = st.den1_oe;
   assign enhanced_mode_o = st.mode[fcrb_pkg::MODE_ENH_BIT];
   assign interface_mode_o = st.mode[fcrb_pkg::MODE_ENC_BIT +: 2];
   assign four_drive_decoder_select_o = st.ext[fcrb_pkg::EXT_X4_BIT];
   assign dma_burst_select_o = st.ext[fcrb_pkg::EXT_DMA_BIT];
   assign drive_type_o = st.dtype;
endmodule

// [core/fcrb_drive_map.sv]
`timescale 1ns/1ps
module fcrb_drive_map (
   // controls
   input wire logic swap_i,
   input wire logic [1:0] den_force_i,
   input wire logic den_rate_i,
   // drive selects from the core
   input wire logic [3:0] sel_i,
   input wire logic [3:0] motor_i,
   // mapped outputs
   output logic [3:0] sel_o,
   output logic [3:0] motor_o,
   output logic den_o
);
   function automatic logic [3:0] swap01(input logic [3:0] v,
                                         input logic s);
      swap01 = s ? {v[3:2], v[0], v[1]} : v;
   endfunction

   always_comb begin
      sel_o = swap01(sel_i, swap_i);
      motor_o = swap01(motor_i, swap_i);
      case (den_force_i)
         fcrb_pkg::DEN_HIGH: den_o = 1'b1;
         fcrb_pkg::DEN_LOW: den_o = 1'b0;
         default: den_o = den_rate_i;
      endcase
   end
endmodule

// [core/fcrb_pin_sync.sv]
`timescale 1ns/1ps
module fcrb_pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } fcrb_sync_t;
   fcrb_sync_t st, next_st;

   always_comb begin
      next_st = st;
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.s2;
endmodule

// [core/fcrb_pkg.sv]
package fcrb_pkg;
   // register indices
   localparam logic [7:0] IDX_LOCK = 8'h01;
   localparam logic [7:0] IDX_RSV2 = 8'h02;
   localparam logic [7:0] IDX_MODE = 8'h03;
   localparam logic [7:0] IDX_RSV4 = 8'h04;
   localparam logic [7:0] IDX_EXT = 8'h05;
   localparam logic [7:0] IDX_DTYPE = 8'h06;
   // reset values
   localparam logic [7:0] RST_LOCK = 8'h90;
   localparam logic [7:0] RST_RSV2 = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h70;
   localparam logic [7:0] RST_RSV4 = 8'h00;
   localparam logic [7:0] RST_EXT = 8'h00;
   localparam logic [7:0] RST_DTYPE = 8'hFF;
   // field positions
   localparam int LOCK_BIT = 7;
   localparam int LOCK_ONE_BIT = 4;
   localparam int MODE_ENH_BIT = 1;
   localparam int MODE_DEN1_BIT = 4;
   localparam int MODE_ENC_BIT = 5;
   localparam int MODE_IFC_BIT = 6;
   localparam int EXT_DMA_BIT = 2;
   localparam int EXT_DEN_LO = 3;
   localparam int EXT_SWAP_BIT = 5;
   localparam int EXT_X4_BIT = 6;
   // writable masks
   localparam logic [7:0] MODE_WMASK = 8'h72;
   localparam logic [7:0] EXT_WMASK = 8'h7C;
   // density force codes and the AT interface code
   localparam logic [1:0] DEN_NORMAL = 2'h0;
   localparam logic [1:0] DEN_HIGH = 2'h2;
   localparam logic [1:0] DEN_LOW = 2'h3;
   localparam logic [1:0] IFC_AT = 2'h3;
endpackage

// [tb/fcrb_config_regs_properties.sv]
`timescale 1ns/1ps
module fcrb_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // host port
   input wire logic cfg_mode_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic port_sel_i,
   input wire logic [3:0] core_sel_i,
   // watched outputs
   input wire logic [7:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic [3:0] drive_sel_o,
   input wire logic second_density_oe_o,
   input wire logic enhanced_mode_o,
   input wire logic [7:0] drive_type_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic dw;
   assign dw = cfg_mode_i & wr_i & port_sel_i;
   AST_RVALID:
      assert property (cfg_mode_i && rd_i |=> rvalid_o)
         else $error("no rvalid");
   AST_NO_RVALID:
      assert property (!(cfg_mode_i && rd_i) |=> !rvalid_o)
         else $error("rvalid");
   AST_RDATA_IDLE:
      assert property (!rvalid_o |-> rdata_o == 8'h00) else $error("rdata");
   AST_MODE_OFF:
      assert property (!cfg_mode_i |=> $stable(drive_type_o))
         else $error("off");
   AST_CFG_STABLE:
      assert property (!dw |=> $stable({enhanced_mode_o, drive_type_o}))
         else $error("cfg moved");
   AST_OE_STABLE:
      assert property (!dw && !$past(dw) && !$past(rst_i) && !$past(rst_i, 2)
         |=> $stable(second_density_oe_o)) else $error("oe moved");
   AST_SEL_HI:
      assert property (1'b1 |=> drive_sel_o[3:2] == $past(core_sel_i[3:2]))
         else $error("sel hi");
   AST_SWAP_PAIR:
      assert property (1'b1 |=> drive_sel_o[1:0] == $past(core_sel_i[1:0]) ||
         drive_sel_o[1:0] == {$past(core_sel_i[0]), $past(core_sel_i[1])})
         else $error("sel lo");
endmodule
bind fcrb_config_regs fcrb_checker fcrb_checker_i (.clk_i, .rst_i,
   .cfg_mode_i, .wr_i, .rd_i, .port_sel_i, .core_sel_i, .rdata_o, .rvalid_o,
   .drive_sel_o, .second_density_oe_o, .enhanced_mode_o, .drive_type_o);

// [tb/fcrb_host_model.sv]
`timescale 1ns/1ps
module fcrb_host_model (
   // clock and answer
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   // strobes
   output logic cfg_mode_o,
   output logic wr_o,
   output logic rd_o,
   output logic port_sel_o,
   output logic [7:0] wdata_o
);
   initial {cfg_mode_o, wr_o, rd_o, port_sel_o, wdata_o} = 12'h000;
   task automatic mode(input logic m);
      @(posedge clk_i);
      #1 cfg_mode_o = m;
   endtask
   // released data is inverted so a stale byte never matches
   task automatic put(input logic p, input logic [7:0] v);
      @(posedge clk_i);
      #1 {wr_o, port_sel_o, wdata_o} = {1'b1, p, v};
      @(posedge clk_i);
      #1 {wr_o, wdata_o} = {1'b0, ~v};
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      put(1'b0, a);
      put(1'b1, v);
   endtask
   task automatic get(input logic [7:0] a, output logic [7:0] q,
                      output logic ok);
      put(1'b0, a);
      @(posedge clk_i);
      #1 {rd_o, port_sel_o} = 2'b11;
      @(posedge clk_i);
      #1 {rd_o, q, ok} = {1'b0, rdata_i, rvalid_i};
   endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
   logic clk_i, rst_i, hard_rst_i, cfg_mode_i, wr_i, rd_i, port_sel_i;
   logic den_rate_i, den1_rate_i, rvalid_o, density_o, enhanced_mode_o;
   logic second_density_output_o, second_density_oe_o, dma_burst_select_o;
   logic four_drive_decoder_select_o;
   logic [1:0] interface_mode_o;
   logic [3:0] core_sel_i, core_motor_i, drive_sel_o, motor_sel_o;
   logic [7:0] wdata_i, rdata_o, drive_type_o, cv;
   int error_cnt = 0;
   int n_tests = 0;
   localparam logic [7:0] RV [6] = '{8'h90, 8'h00, 8'h70, 8'h00, 8'h00,
      8'hFF};
   localparam logic [7:0] WV [6] = '{8'h90, 8'h00, 8'h72, 8'h00, 8'h7C,
      8'hFF};
   assign cv = {enhanced_mode_o, interface_mode_o, second_density_oe_o,
      four_drive_decoder_select_o, dma_burst_select_o, 2'b00};
   fcrb_config_regs fcrb_config_regs_i (.clk_i, .rst_i, .hard_rst_i,
      .cfg_mode_i, .wr_i, .rd_i, .port_sel_i, .wdata_i, .rdata_o, .rvalid_o,
      .core_sel_i, .core_motor_i, .den_rate_i, .den1_rate_i, .drive_sel_o,
      .motor_sel_o, .density_o, .second_density_output_o,
      .second_density_oe_o, .enhanced_mode_o, .interface_mode_o,
      .four_drive_decoder_select_o, .dma_burst_select_o, .drive_type_o);
   fcrb_host_model fcrb_host_model_i (.clk_i, .rdata_i(rdata_o),
      .rvalid_i(rvalid_o), .cfg_mode_o(cfg_mode_i), .wr_o(wr_i),
      .rd_o(rd_i), .port_sel_o(port_sel_i), .wdata_o(wdata_i));
   task automatic chk(input string n, input logic [7:0] s, e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic rc(input logic [7:0] a, e, input logic v);
      logic [7:0] q;
      logic ok;
      fcrb_host_model_i.get(a, q, ok);
      chk("rvalid", {7'h00, ok}, {7'h00, v});
      chk("rdata", q, e);
   endtask
   task automatic wr(input logic [7:0] a, v);
      fcrb_host_model_i.wreg(a, v);
      #100;
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      #50us;
      error_cnt++;
      final_report;
   end
   initial begin
      {rst_i, hard_rst_i, den_rate_i, den1_rate_i} = 4'h8;
      {core_sel_i, core_motor_i} = 8'h00;
      repeat (20) @(posedge clk_i);
      #1 rst_i = 1'b0;
      fcrb_host_model_i.mode(1'b1);
      for (int i = 0; i < 6; i++) rc(8'(i + 1), RV[i], 1'b1);
      chk("cfg", cv, 8'h60);
      for (int i = 0; i < 6; i++) wr(8'(i + 1), 8'hFF);
      for (int i = 0; i < 6; i++) rc(8'(i + 1), WV[i], 1'b1);
      chk("cfg", cv, 8'hEC);
      wr(8'h03, 8'h00);
      chk("cfg", cv, 8'h1C);
      den1_rate_i = 1'b1;
      wr(8'h05, 8'h10);
      chk("den", {6'h00, density_o, second_density_output_o}, 8'h03);
      den_rate_i = 1'b1;
      wr(8'h05, 8'h18);
      chk("den", {7'h00, density_o}, 8'h00);
      {core_sel_i, core_motor_i} = 8'h12;
      wr(8'h05, 8'h20);
      chk("pins", {drive_sel_o, motor_sel_o}, 8'h21);
      chk("den", {7'h00, density_o}, 8'h01);
      wr(8'h06, 8'h3C);
      fcrb_host_model_i.mode(1'b0);
      wr(8'h06, 8'h00);
      rc(8'h06, 8'h00, 1'b0);
      fcrb_host_model_i.mode(1'b1);
      chk("dtype", drive_type_o, 8'h3C);
      wr(8'h01, 8'h7F);
      wr(8'h06, 8'h00);
      wr(8'h01, 8'h80);
      rc(8'h01, 8'h00, 1'b1);
      chk("dtype", drive_type_o, 8'h3C);
      hard_rst_i = 1'b1;
      #25 hard_rst_i = 1'b0;
      rc(8'h01, 8'h90, 1'b1);
      rc(8'h06, 8'h3C, 1'b1);
      rst_i = 1'b1;
      #50 rst_i = 1'b0;
      rc(8'h06, 8'hFF, 1'b1);
      final_report;
   end
endmodule
